//--- core/dbg_req_engine.sv
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module dbg_req_engine
    import dbg_req_pkg::*;
#(
    parameter int TOUT = TOUT_CYC
)(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_port_susp,
    input wire logic i_port_rst,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    input wire logic i_tx_ready,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_last,
    input wire logic i_rx_err
);
    // Whole state of the block
    typedef struct packed {
        logic pend;         // Data phase pending
        logic wr;           // Pending access is a write
        logic [4:0] ofs;    // Pending register offset
        logic rdy;          // Bus ready
        logic [31:0] rdat;  // Read data
        logic claim;        // Software-owned claim bit
        logic [2:0] cause;  // Failure cause
        logic fail;         // Failure flag
        logic go;           // Launch pending
        logic dir;          // 1 write, 0 read
        logic [3:0] len;    // Byte count
        logic done;         // Request complete
        logic [7:0] ret;    // Returned pid
        logic [7:0] snd;    // Outgoing data pid
        logic [7:0] tok;    // Token pid
        logic [63:0] buff;  // Data buffer
        logic [6:0] addr;   // Target address
        logic [3:0] ep;     // Target endpoint
        state_t st;         // Engine state
        logic [3:0] idx;    // Byte index
        logic [31:0] tmr;   // Answer timer
        logic txv;          // Transmit byte valid
        logic [7:0] txd;    // Transmit byte
        logic txl;          // Last byte of packet
    } regs_t;

    regs_t q;
    regs_t d;

    // Pick buffer byte n
    function automatic logic [7:0] buf_byte(logic [63:0] b,
                                            logic [3:0] n);
        buf_byte = b[{n[2:0], 3'h0} +: 8];
    endfunction

    // Read mux over the register map
    function automatic logic [31:0] rd_word(regs_t r, logic [4:0] a);
        rd_word = 32'h0;
        case (a)
            OFS_CTRL:
            begin
                rd_word[B_DONE] = r.done;
                rd_word[B_CLAIM] = r.claim;
                rd_word[B_CAUSE +: 3] = r.cause;
                rd_word[B_FAIL] = r.fail;
                rd_word[B_GO] = r.go;
                rd_word[B_DIR] = r.dir;
                rd_word[B_LEN +: 4] = r.len;
            end
            OFS_PIDS: rd_word = {8'h0, r.ret, r.snd, r.tok}; // R13
            OFS_BUFL: rd_word = r.buff[31:0];
            OFS_BUFH: rd_word = r.buff[63:32];
            OFS_CFG:
            begin
                rd_word[B_ADDR +: 7] = r.addr;
                rd_word[B_EP +: 4] = r.ep;
            end
            default: rd_word = 32'h0;
        endcase
    endfunction

    logic fin;              // Request ends this cycle
    logic [2:0] fin_cause;  // Its outcome
    logic tx_go;            // Current byte accepted

    // Next-state logic for bus, registers and engine
    always_comb
    begin
        d = q;
        fin = 1'b0;
        fin_cause = CAUSE_NONE;
        tx_go = q.txv && i_tx_ready;
        // Address phase: take request, stall one cycle
        if (i_hsel && i_hready && i_htrans[1])
        begin
            d.pend = 1'b1;
            d.wr = i_hwrite;
            d.ofs = i_haddr[4:0];
            d.rdy = 1'b0;
        end
        // Data phase: write, then answer
        if (q.pend)
        begin
            d.pend = 1'b0;
            d.rdy = 1'b1;
            d.rdat = rd_word(q, q.ofs);
            if (q.wr)
            begin
                case (q.ofs)
                    OFS_CTRL:
                    begin
                        d.claim = i_hwdata[B_CLAIM]; // R1
                        d.dir = i_hwdata[B_DIR]; // R9
                        d.len = i_hwdata[B_LEN +: 4]; // R10
                        if (i_hwdata[B_GO])
                            d.go = 1'b1; // R6
                        if (i_hwdata[B_DONE])
                            d.done = 1'b0; // R19
                    end
                    OFS_PIDS:
                    begin
                        d.snd = i_hwdata[B_SND +: 8];
                        d.tok = i_hwdata[B_TOK +: 8];
                    end
                    OFS_BUFL: d.buff[31:0] = i_hwdata;
                    OFS_BUFH: d.buff[63:32] = i_hwdata;
                    OFS_CFG:
                    begin
                        d.addr = i_hwdata[B_ADDR +: 7];
                        d.ep = i_hwdata[B_EP +: 4];
                    end
                    default: d.claim = q.claim;
                endcase
            end
        end
        // Answer timer runs while waiting for a packet
        d.tmr = (q.st == ST_RXW || q.st == ST_RXD) ? q.tmr + 32'h1 :
            32'h0;
        // Transmit byte leaves on acceptance
        if (tx_go)
            d.txv = 1'b0;
        // Engine
        case (q.st)
            ST_IDLE:
            begin
                if (q.go && (i_port_susp || i_port_rst))
                begin
                    fin = 1'b1; // R3
                    fin_cause = CAUSE_HW; // R3
                end
                else if (q.go)
                begin
                    d.st = ST_TOK; // R21
                    d.idx = 4'h0;
                    d.txv = 1'b1;
                    d.txd = q.tok; // R17
                    d.txl = 1'b0;
                end
            end
            ST_TOK:
            begin
                if (tx_go)
                begin
                    d.idx = q.idx + 4'h1;
                    d.txv = 1'b1;
                    if (q.idx == 4'h0)
                        d.txd = {q.ep[0], q.addr}; // R20
                    else if (q.idx == 4'h1)
                    begin
                        d.txd = {5'h0, q.ep[3:1]}; // R20
                        d.txl = 1'b1;
                    end
                    else if (q.dir)
                    begin
                        d.st = ST_DOUT;
                        d.idx = 4'h0;
                        d.txd = q.snd; // R16
                        d.txl = (q.len == 4'h0); // R10
                    end
                    else
                    begin
                        d.st = ST_RXW;
                        d.txv = 1'b0;
                    end
                end
            end
            ST_DOUT:
            begin
                if (tx_go && q.txl)
                    d.st = ST_RXW;
                else if (tx_go)
                begin
                    d.txv = 1'b1;
                    d.txd = buf_byte(q.buff, q.idx); // R12
                    d.txl = (q.idx + 4'h1 == q.len);
                    d.idx = q.idx + 4'h1;
                end
            end
            ST_RXW:
            begin
                if (i_rx_valid && i_rx_err)
                begin
                    fin = 1'b1; // R4
                    fin_cause = CAUSE_TRANS; // R4
                end
                else if (i_rx_valid)
                begin
                    d.ret = i_rx_data; // R14 R15
                    d.idx = 4'h0;
                    if (!i_rx_last)
                    begin
                        if (!q.dir && (i_rx_data == PID_DATA0 ||
                            i_rx_data == PID_DATA1))
                            d.st = ST_RXD;
                        else
                        begin
                            fin = 1'b1; // R4
                            fin_cause = CAUSE_TRANS;
                        end
                    end
                    else if (!q.dir && (i_rx_data == PID_DATA0 ||
                        i_rx_data == PID_DATA1))
                    begin
                        d.len = 4'h0; // R11
                        d.st = ST_HS;
                        d.txv = 1'b1;
                        d.txd = PID_ACK;
                        d.txl = 1'b1;
                    end
                    else
                    begin
                        fin = 1'b1; // R5
                        if (!q.dir)
                            d.len = 4'h0; // R11
                    end
                end
                else if (q.tmr >= 32'(TOUT))
                begin
                    fin = 1'b1; // R4
                    fin_cause = CAUSE_TRANS;
                end
            end
            ST_RXD:
            begin
                if (i_rx_valid && (i_rx_err || q.idx == MAX_LEN))
                begin
                    fin = 1'b1; // R4
                    fin_cause = CAUSE_TRANS;
                end
                else if (i_rx_valid)
                begin
                    d.buff[{q.idx[2:0], 3'h0} +: 8] = i_rx_data; // R12
                    d.idx = q.idx + 4'h1;
                    if (i_rx_last)
                    begin
                        d.len = q.idx + 4'h1; // R11
                        d.st = ST_HS;
                        d.txv = 1'b1;
                        d.txd = PID_ACK;
                        d.txl = 1'b1;
                    end
                end
                else if (q.tmr >= 32'(TOUT))
                begin
                    fin = 1'b1;
                    fin_cause = CAUSE_TRANS; // R4
                end
            end
            ST_HS:
            begin
                if (tx_go)
                    fin = 1'b1; // R5
            end
            default: d.st = ST_IDLE;
        endcase
        // Suspend or reset in flight aborts the request
        if (q.st != ST_IDLE && (i_port_susp || i_port_rst))
        begin
            fin = 1'b1; // R3
            fin_cause = CAUSE_HW;
        end
        // Completion: set wins over a software clear
        if (fin)
        begin
            d.st = ST_IDLE;
            d.txv = 1'b0;
            d.go = 1'b0; // R7
            d.done = 1'b1; // R19
            d.fail = (fin_cause != CAUSE_NONE); // R5
            d.cause = fin_cause; // R2
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            q <= '0; // R18
            q.rdy <= 1'b1;
            q.addr <= RST_ADDR;
            q.ep <= RST_EP;
            q.st <= ST_IDLE;
        end
        else
            q <= d;
    end

    // Outputs straight from flops, except o_hresp tied low
    assign o_hrdata = q.rdat;
    assign o_hreadyout = q.rdy;
    assign o_hresp = 1'b0;
    assign o_tx_valid = q.txv;
    assign o_tx_data = q.txd;
    assign o_tx_last = q.txl;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    // Launch taken from idle with the port healthy
    sequence s_launch;
        q.st == ST_IDLE && q.go && !i_port_susp && !i_port_rst;
    endsequence
    // Request end marker
    sequence s_end;
        q.done && !q.go;
    endsequence

    property p_go_done;
        $fell(q.go) |-> s_end;
    endproperty
    a_go_done: assert property (p_go_done) // R7
        else $error("launch cleared without completion");

    property p_cause;
        q.fail |-> (q.cause == CAUSE_TRANS || q.cause == CAUSE_HW);
    endproperty
    a_cause: assert property (p_cause) // R2
        else $error("bad failure cause");

    property p_hw;
        q.st == ST_IDLE && q.go && i_port_susp
            |=> q.fail && q.cause == CAUSE_HW && !q.go;
    endproperty
    a_hw: assert property (p_hw) // R3
        else $error("suspend did not give hardware error");

    // Suspend or reset while a request runs ends it as a hardware error
    property p_abort;
        q.st != ST_IDLE && (i_port_susp || i_port_rst)
            |=> q.fail && q.cause == CAUSE_HW && !q.go;
    endproperty
    a_abort: assert property (p_abort) // R3
        else $error("abort did not give hardware error");

    property p_terr;
        q.st == ST_RXW && i_rx_valid && i_rx_err && !i_port_susp &&
            !i_port_rst |=> q.fail && q.cause == CAUSE_TRANS;
    endproperty
    a_terr: assert property (p_terr) // R4
        else $error("receive error not reported");

    property p_ok;
        q.st == ST_HS && i_tx_ready && !i_port_susp && !i_port_rst
            |=> !q.fail and s_end;
    endproperty
    a_ok: assert property (p_ok) // R5
        else $error("good end left failure set");

    property p_tok;
        s_launch |=> o_tx_valid && o_tx_data == $past(q.tok);
    endproperty
    a_tok: assert property (p_tok) // R17
        else $error("token pid not sent first");

    property p_addr;
        q.st == ST_TOK && q.idx == 4'h1 && o_tx_valid
            |-> o_tx_data[6:0] == q.addr;
    endproperty
    a_addr: assert property (p_addr) // R20
        else $error("token address wrong");

    property p_snd;
        q.st == ST_DOUT && q.idx == 4'h0 && o_tx_valid
            |-> o_tx_data == q.snd;
    endproperty
    a_snd: assert property (p_snd) // R16
        else $error("data pid wrong");

    property p_len;
        q.len <= MAX_LEN || q.dir;
    endproperty
    a_len: assert property (p_len) // R11
        else $error("read count above eight");

    property p_rsv;
        q.pend && !q.wr && q.ofs == OFS_PIDS |=> o_hrdata[31:24] == 8'h0;
    endproperty
    a_rsv: assert property (p_rsv) // R13
        else $error("reserved pid bits not zero");
endmodule

//--- core/dbg_req_pkg.sv
// Notes on behaviour
// R1 - Port-claimed bit is software-only, no effect
// R2 - Failure cause: 000 none, 001 transaction, 010 hardware
// R3 - Request while suspended or reset: hardware error
// R4 - CRC, bad PID, timeout: transaction error
// R5 - Failure flag cleared on good end, set on error
// R6 - Writing launch bit starts one request
// R7 - Launch bit clears as completion flag sets
// R8 - Software never relaunches while launch still set
// R9 - Direction bit: 0 read, 1 write, resets read
// R10 - Write byte count 0 to 8, 0 is ZLP
// R11 - Reads store received byte count, never above 8
// R12 - Bytes move from buffer byte 0 upward
// R13 - Reserved bits read zero, ignore writes
// R14 - Returned PID: handshake, data PID, or NAK
// R15 - Returned PID valid once launch bit clears
// R16 - Write data packet starts with outgoing PID
// R17 - Every transaction starts with token PID field
// R18 - PID register, count, cause reset to zero
// R19 - Completion flag set by hardware, write-one-clear
// R20 - Tokens carry configured address and endpoint
// R21 - One transaction: token, data, handshake
package dbg_req_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_PIDS = 5'h04;
    localparam logic [4:0] OFS_BUFL = 5'h08;
    localparam logic [4:0] OFS_BUFH = 5'h0c;
    localparam logic [4:0] OFS_CFG = 5'h10;
    // Control field positions
    localparam int B_DONE = 16;
    localparam int B_CLAIM = 10;
    localparam int B_CAUSE = 7;
    localparam int B_FAIL = 6;
    localparam int B_GO = 5;
    localparam int B_DIR = 4;
    localparam int B_LEN = 0;
    // Pid register field positions
    localparam int B_RET = 16;
    localparam int B_SND = 8;
    localparam int B_TOK = 0;
    // Config field positions and reset values
    localparam int B_ADDR = 8;
    localparam int B_EP = 0;
    localparam logic [6:0] RST_ADDR = 7'h7f;
    localparam logic [3:0] RST_EP = 4'h1;
    // Failure cause codes
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_TRANS = 3'h1;
    localparam logic [2:0] CAUSE_HW = 3'h2;
    // Packet ids with check nibble
    localparam logic [7:0] PID_ACK = 8'hd2;
    localparam logic [7:0] PID_DATA0 = 8'hc3;
    localparam logic [7:0] PID_DATA1 = 8'h4b;
    // Largest payload
    localparam logic [3:0] MAX_LEN = 4'h8;
    // Wait for an answer packet
    localparam int CLK_MHZ = 100;
    localparam int TOUT_NS = 10000;
    localparam int TOUT_CYC = TOUT_NS * CLK_MHZ / 1000;
    // Engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_TOK, ST_DOUT, ST_RXW, ST_RXD, ST_HS
    } state_t;
endpackage

//--- verification/debug_console_model.sv
`timescale 1ns/1ps
module debug_console_model (
    input wire logic i_clk,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_last,
    output logic o_rx_err
);
    logic [8:0] txq [$]; // Taken bytes, last flag on top
    logic [7:0] rxq [$]; // Answer packet, first byte is the pid
    logic slow = 1'b0; // Stall every other cycle when set

    initial
    begin
        o_tx_ready = 1'b0;
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_rx_last = 1'b0;
        o_rx_err = 1'b0;
    end

    // Take offered bytes, with optional stalls
    always @(posedge i_clk)
    begin
        if (i_tx_valid && o_tx_ready)
        begin
            txq.push_back({i_tx_last, i_tx_data});
        end
        o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    end

    // Answer after the host's packets, one byte a cycle
    task send_pkt(input logic bad);
        while (rxq.size() > 0)
        begin
            @(posedge i_clk);
            o_rx_valid <= 1'b1;
            o_rx_data <= rxq.pop_front();
            o_rx_last <= (rxq.size() == 0);
            o_rx_err <= bad;
        end
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_last <= 1'b0;
        o_rx_err <= 1'b0;
        // Released data line shows no stale byte
        o_rx_data <= ~o_rx_data;
    endtask
endmodule

//--- verification/usb_debug_port_request_engine_tb.sv
`timescale 1ns/1ps
module usb_debug_port_request_engine_tb;
    import dbg_req_pkg::*;
    localparam logic [7:0] TK_OUT = 8'he1; // Out token pid
    localparam logic [7:0] TK_IN = 8'h69; // In token pid
    localparam logic [7:0] HS_NAK = 8'h5a; // Not-ready handshake
    localparam logic [31:0] RD_GO = 32'h0001_0420; // Clear done, launch read
    logic clk = 1'b0; // Bench clock
    logic rstn = 1'b0; // Reset, active low
    logic hsel = 1'b0; // Bus select
    logic hwrite = 1'b0; // Bus direction
    logic [1:0] htrans = 2'h0; // Bus transfer kind
    logic [2:0] hsize = 3'h0; // Bus transfer size
    logic [31:0] haddr = 32'h0; // Bus address
    logic [31:0] hwdata = 32'h0; // Bus write data
    logic susp = 1'b0; // Port suspended
    logic prst = 1'b0; // Port in reset
    logic [31:0] rd; // Last read word
    wire logic [31:0] hrdata; // Bus read data
    wire logic hready; // Single slave ready
    wire logic hresp; // Bus response
    wire logic tx_valid, tx_last, tx_ready, rx_valid, rx_last, rx_err;
    wire logic [7:0] tx_data, rx_data; // Link bytes
    int n_errors = 0; // Mismatches
    int num_checks = 0; // Comparisons
    int cycles = 0; // Cycles run

    dbg_req_engine #(.TOUT(40)) uut (
        .i_clk(clk), .i_rstn(rstn), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp), .i_port_susp(susp),
        .i_port_rst(prst), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
        .o_tx_last(tx_last), .i_tx_ready(tx_ready), .i_rx_valid(rx_valid),
        .i_rx_data(rx_data), .i_rx_last(rx_last), .i_rx_err(rx_err));

    debug_console_model link (
        .i_clk(clk), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .i_tx_last(tx_last), .o_tx_ready(tx_ready), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data), .o_rx_last(rx_last), .o_rx_err(rx_err));

    // Clock of 10 ns
    always #5 clk = ~clk;

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("mismatch at %0t: run too long", $time);
            end_of_test();
        end
    end

    // Verdict and end of run
    task end_of_test();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Compare a word
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One bus transfer; the data phase waits for ready
    task bus(input logic wr, input logic [4:0] ofs, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {27'h0, ofs};
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask

    // Read a word and compare it
    task rchk(input logic [4:0] ofs, input logic [31:0] exp);
        bus(1'b0, ofs, 32'h0);
        check(rd, exp);
    endtask

    // Poll for the completion flag
    task wait_done();
        int k;
        for (k = 0; k < 100; k++)
        begin
            bus(1'b0, OFS_CTRL, 32'h0);
            if (rd[B_DONE] === 1'b1) break;
        end
        check({31'h0, rd[B_DONE]}, 32'h1);
    endtask

    // Wait until the link holds n bytes
    task wait_tx(input int n);
        int k;
        for (k = 0; k < 300 && link.txq.size() < n; k++) @(posedge clk);
        check(link.txq.size(), n);
    endtask

    // Compare one byte taken by the link
    task chk_tx(input int i, input logic [8:0] e);
        check({23'h0, link.txq[i]}, {23'h0, e});
    endtask

    // Launch with a clean log, then check the token
    task launch(input logic [31:0] w, input logic [7:0] tok);
        link.txq.delete();
        bus(1'b1, OFS_CTRL, w);
        wait_tx(3);
        chk_tx(0, {1'b0, tok});
        chk_tx(1, 9'h095);
        chk_tx(2, 9'h102);
    endtask

    // Reset values, reserved and read-only bits
    task t_reset();
        rchk(OFS_CTRL, 32'h0);
        rchk(OFS_PIDS, 32'h0);
        rchk(OFS_CFG, 32'h0000_7f01);
        rchk(5'h14, 32'h0);
        bus(1'b1, OFS_PIDS, 32'hffff_ffff);
        rchk(OFS_PIDS, 32'h0000_ffff);
        bus(1'b1, OFS_CTRL, 32'h0000_0c00);
        rchk(OFS_CTRL, 32'h0000_0400);
    endtask

    // Write of three bytes with a slow link
    task t_write();
        bus(1'b1, OFS_CFG, 32'h0000_1505);
        bus(1'b1, OFS_BUFL, 32'h4433_2211);
        bus(1'b1, OFS_BUFH, 32'h8877_6655);
        bus(1'b1, OFS_PIDS, {16'h0, PID_DATA1, TK_OUT});
        link.slow = 1'b1;
        launch(32'h0001_0433, TK_OUT);
        wait_tx(7);
        chk_tx(3, {1'b0, PID_DATA1});
        chk_tx(4, 9'h011);
        chk_tx(5, 9'h022);
        chk_tx(6, 9'h133);
        link.slow = 1'b0;
        link.rxq = '{PID_ACK};
        link.send_pkt(1'b0);
        wait_done();
        check(rd, 32'h0001_0413);
        rchk(OFS_PIDS, {8'h0, PID_ACK, PID_DATA1, TK_OUT});
    endtask

    // Bad packet or no answer ends with a transaction error
    task t_trans(input logic bad);
        bus(1'b1, OFS_PIDS, {16'h0, PID_DATA1, TK_IN});
        launch(RD_GO, TK_IN);
        if (bad)
        begin
            link.rxq = '{PID_DATA0, 8'h01};
            link.send_pkt(1'b1);
        end
        wait_done();
        check(rd & 32'hffff_fff0, 32'h0001_04c0);
    endtask

    // Handshake-only answer to a read
    task t_nak();
        launch(RD_GO, TK_IN);
        link.rxq = '{HS_NAK};
        link.send_pkt(1'b0);
        wait_done();
        check(rd, 32'h0001_0400);
        rchk(OFS_PIDS, {8'h0, HS_NAK, PID_DATA1, TK_IN});
    endtask

    // Request on a suspended or reset port
    task t_hw(input logic in_rst);
        if (in_rst)
            prst <= 1'b1;
        else
            susp <= 1'b1;
        bus(1'b1, OFS_CTRL, RD_GO);
        wait_done();
        check(rd & 32'hffff_fff0, 32'h0001_0540);
        susp <= 1'b0;
        prst <= 1'b0;
    endtask

    // Port reset while a read waits for its answer
    task t_abort();
        launch(RD_GO, TK_IN);
        prst <= 1'b1;
        wait_done();
        check(rd & 32'hffff_fff0, 32'h0001_0540);
        prst <= 1'b0;
    endtask

    // Read of four bytes, then clearing the completion flag
    task t_read();
        launch(RD_GO, TK_IN);
        link.rxq = '{PID_DATA0, 8'ha1, 8'hb2, 8'hc3, 8'hd4};
        link.send_pkt(1'b0);
        wait_tx(4);
        chk_tx(3, {1'b1, PID_ACK});
        wait_done();
        check(rd, 32'h0001_0404);
        rchk(OFS_BUFL, 32'hd4c3_b2a1);
        rchk(OFS_BUFH, 32'h8877_6655);
        rchk(OFS_PIDS, {8'h0, PID_DATA0, PID_DATA1, TK_IN});
        bus(1'b1, OFS_CTRL, 32'h0001_0404);
        rchk(OFS_CTRL, 32'h0000_0404);
    endtask

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_write();
        t_trans(1'b1);
        t_trans(1'b0);
        t_nak();
        t_hw(1'b0);
        t_hw(1'b1);
        t_abort();
        t_read();
        end_of_test();
    end
endmodule
